// >>> nvm_modify_and_eeprom_write.sv
// serial sequencer: modify code memory, write data eeprom
// What this block does
// - code writes need full 8-byte buffer in single panel mode
// - row erase covers 64 bytes, single panel
// - no row erase or eeprom write without write enable; table writes skip it
// - row-erase bit erases row at table pointer
// - write-initiate bit starts the selected operation
// - initiate needs key 55h then AAh
// - erase starts on fourth clock fall
// - writing 00h to 3C0006h selects single panel
// - command 1101 stores word, pointer plus two
// - command 1111 stores last word, starts programming
// - eeprom written bytewise, erase before write
// - eeprom write at fourth fall, hardware clears
// - ID locations at 200000h to 200007h
// - ID locations readable under code protection
// - boot block written single panel, 0000h-07FFh
// - commands shifted in least significant bit first
`timescale 1ns/10ps
`include "nvm_seq_regs.svh"
module nvm_modify_and_eeprom_write #(
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input  wire logic               i_sys_clk,
	input  wire logic               i_rst_b,
	// programming pins
	input  wire logic               i_prog_serial_clock,
	input  wire logic               i_prog_serial_data,
	output logic                    o_prog_serial_data_out,
	output logic                    o_prog_serial_data_oe,
	// memory request stream
	output logic                    o_mem_valid,
	input  wire logic               i_mem_ready,
	output nvm_seq_pkg::mem_op_type o_mem_op,
	input  wire logic               i_mem_done,
	// status
	output logic                    o_write_busy,
	output logic                    o_single_panel,
	output logic                    o_program_refused,
	output logic                    o_overrun
);

	// synchronised pins
	logic        clk_lvl;          // filtered serial clock
	logic        din_lvl;          // filtered serial data
	logic        clk_prev_r;       // clock one cycle ago
	logic        fall;             // serial clock falling edge
	logic        rise;             // serial clock rising edge
	// framing
	nvm_seq_pkg::link_state_type state_r;
	logic [3:0]  cnt_r;            // bits taken in this phase
	logic [3:0]  cmd_sr_r;         // command shifter
	logic [3:0]  cmd_r;            // command being served
	logic [15:0] pay_sr_r;         // payload shifter
	logic [15:0] pay_full;         // payload incl. the last bit
	logic        exec;             // payload complete this cycle
	logic        tw_cmd;           // command is a table write
	// device registers
	logic [7:0]  w_r;              // working register
	logic [21:0] tp_r;             // table_pointer
	logic [7:0]  table_latch_r;    // table_latch
	logic [7:0]  mac_r;            // memory_access_control
	logic [7:0]  pctl_r;           // programming_control
	logic [7:0]  ee_lo_r;          // eeprom_addr_low
	logic [7:0]  ee_hi_r;          // eeprom_addr_high
	logic [7:0]  ee_data_r;        // eeprom_data_latch
	nvm_seq_pkg::key_state_type key_r;
	// instruction decode
	logic [7:0]  rd_val;           // value of the addressed register
	logic        sfr_we;           // register write strobe
	logic [7:0]  sfr_wdata;        // register write value
	logic        w_we;             // working register write strobe
	logic [7:0]  w_data;           // working register write value
	logic        key_keep;         // instruction keeps key progress
	logic        wr_go;            // accepted write initiate
	// initiate countdown
	logic        wait_r;           // counting edges after initiate
	logic [2:0]  edge_cnt_r;       // falls seen since initiate
	logic        launch;           // fourth fall reached
	logic        launch_erase;     // launch is a row erase
	logic        launch_ee;        // launch is an eeprom byte
	logic        ee_wait_r;        // eeprom byte in flight
	logic        wr_clear;         // hardware clears initiate
	// buffer tracking
	logic [3:0]  mask_r;           // loaded word slots
	logic [18:0] group_r;          // eight-byte group of mask_r
	logic [3:0]  cur_mask;         // slots valid for pointer group
	logic [3:0]  slot;             // slot of the pointer
	logic        full;             // buffer complete with this word
	logic        pctl_hit;         // table write hits control
	logic        multi;            // multi-panel mode
	// requests
	logic        new_valid;
	nvm_seq_pkg::mem_op_type new_op;
	logic        pend_valid_r;
	nvm_seq_pkg::mem_op_type pend_op_r;
	logic        buf_ready;
	logic        accept;

	generate
		if (BUF_DEPTH < 2) begin : g_chk
			$error("request buffer needs at least two entries");
		end
	endgenerate

	// clock and data share one synchroniser
	pin_sync #(
		.WIDTH (2)
	) u_pins (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_async   ({i_prog_serial_clock, i_prog_serial_data}),
		.o_level   ({clk_lvl, din_lvl})
	);

	// edge finder on the serial clock
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			clk_prev_r <= 1'h0;
		end else begin
			clk_prev_r <= clk_lvl;
		end
	end

	assign fall     = clk_prev_r & ~clk_lvl;
	assign rise     = ~clk_prev_r & clk_lvl;
	assign pay_full = {din_lvl, pay_sr_r[15:1]};
	assign exec     = fall && (state_r == nvm_seq_pkg::ST_PAY) && (cnt_r == `PAY_LAST_BIT);
	assign tw_cmd   = (cmd_r == `CMD_TW) || (cmd_r == `CMD_TW_INC) || (cmd_r == `CMD_TW_PROG);

	// lsb first
	// 4 command then 16 payload bits, taken on falls
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r  <= nvm_seq_pkg::ST_CMD;
			cnt_r    <= 4'h0;
			cmd_sr_r <= 4'h0;
			cmd_r    <= 4'h0;
			pay_sr_r <= 16'h0000;
		end else if (fall) begin
			case (state_r)
				nvm_seq_pkg::ST_CMD: begin
					cmd_sr_r <= {din_lvl, cmd_sr_r[3:1]};
					if (cnt_r == `CMD_LAST_BIT) begin
						cmd_r   <= {din_lvl, cmd_sr_r[3:1]};
						cnt_r   <= 4'h0;
						state_r <= nvm_seq_pkg::ST_PAY;
					end else begin
						cnt_r <= cnt_r + 4'h1;
					end
				end
				nvm_seq_pkg::ST_PAY: begin
					pay_sr_r <= pay_full;
					cnt_r    <= cnt_r + 4'h1;
					if (cnt_r == `PAY_LAST_BIT) begin
						state_r <= nvm_seq_pkg::ST_CMD;
					end
				end
				default: begin
					state_r <= nvm_seq_pkg::ST_CMD;
				end
			endcase
		end
	end

	// read mux of the addressed register
	always_comb begin
		case (pay_full[7:0])
			`SFR_TBL_UPPER:  rd_val = {2'h0, tp_r[21:16]};
			`SFR_TBL_HIGH:   rd_val = tp_r[15:8];
			`SFR_TBL_LOW:    rd_val = tp_r[7:0];
			`SFR_TBL_LATCH:  rd_val = table_latch_r;
			`SFR_MAC:        rd_val = mac_r;
			`SFR_EE_DATA:    rd_val = ee_data_r;
			`SFR_EE_ADDR_LO: rd_val = ee_lo_r;
			`SFR_EE_ADDR_HI: rd_val = ee_hi_r;
			default:         rd_val = 8'h00;
		endcase
	end

	// core instruction
	// decode of supported core instructions
	always_comb begin
		sfr_we    = 1'h0;
		sfr_wdata = 8'h00;
		w_we      = 1'h0;
		w_data    = 8'h00;
		key_keep  = 1'h0;
		if (exec && cmd_r == `CMD_CORE) begin
			if (pay_full[15:8] == 8'h0E) begin
				// literal move
				w_we     = 1'h1;
				w_data   = pay_full[7:0];
				key_keep = 1'h1;
			end else if (pay_full[15:9] == 7'h37) begin
				// move working register out
				sfr_we    = 1'h1;
				sfr_wdata = w_r;
			end else if (pay_full[15:9] == 7'h35) begin
				// clear register
				sfr_we = 1'h1;
			end else if (pay_full[15:12] == 4'h8) begin
				// bit set
				sfr_we    = 1'h1;
				sfr_wdata = rd_val | (8'h01 << pay_full[11:9]);
			end else if (pay_full[15:12] == 4'h9) begin
				// bit clear
				sfr_we    = 1'h1;
				sfr_wdata = rd_val & ~(8'h01 << pay_full[11:9]);
			end else if (pay_full[15:10] == 6'h0A) begin
				// increment, to register or w
				sfr_we    = pay_full[9];
				sfr_wdata = rd_val + 8'h01;
				w_we      = ~pay_full[9];
				w_data    = rd_val + 8'h01;
			end else if (pay_full[15:10] == 6'h14) begin
				// move register, to itself or w
				sfr_we    = pay_full[9];
				sfr_wdata = rd_val;
				w_we      = ~pay_full[9];
				w_data    = rd_val;
			end else if (pay_full == 16'h0000) begin
				// no operation
				key_keep = 1'h1;
			end
		end
	end

	// working register
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			w_r <= 8'h00;
		end else if (w_we) begin
			w_r <= w_data;
		end
	end

	// unlock key
	// key 55h then AAh, only literal moves and no operations between
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			key_r <= nvm_seq_pkg::KEY_IDLE;
		end else if (exec) begin
			if (sfr_we && pay_full[7:0] == `SFR_KEY) begin
				if (sfr_wdata == `KEY_FIRST) begin
					key_r <= nvm_seq_pkg::KEY_HALF;
				end else if (sfr_wdata == `KEY_SECOND && key_r == nvm_seq_pkg::KEY_HALF) begin
					key_r <= nvm_seq_pkg::KEY_ARMED;
				end else begin
					key_r <= nvm_seq_pkg::KEY_IDLE;
				end
			end else if (!key_keep) begin
				key_r <= nvm_seq_pkg::KEY_IDLE;
			end
		end
	end

	// write enable
	// initiate taken only if enabled before and key armed
	assign wr_go = sfr_we && (pay_full[7:0] == `SFR_MAC) && sfr_wdata[`MAC_WR]
		&& !mac_r[`MAC_WR] && mac_r[`MAC_WRITE_ENABLE_BIT] && (key_r == nvm_seq_pkg::KEY_ARMED);

	// fourth fall
	// count falls after an accepted initiate
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wait_r     <= 1'h0;
			edge_cnt_r <= 3'h0;
		end else if (wr_go) begin
			wait_r     <= 1'h1;
			edge_cnt_r <= 3'h0;
		end else if (launch) begin
			wait_r <= 1'h0;
		end else if (wait_r && fall) begin
			edge_cnt_r <= edge_cnt_r + 3'h1;
		end
	end

	assign launch       = wait_r && fall && (edge_cnt_r == (`ERASE_START_EDGES - 3'h1));
	assign launch_erase = mac_r[`MAC_PGM_SEL] & ~mac_r[`MAC_CFG_SEL] & mac_r[`MAC_ROW_ERASE];
	assign launch_ee    = ~mac_r[`MAC_PGM_SEL] & ~mac_r[`MAC_CFG_SEL];

	// hardware clears
	// eeprom initiate held until the byte is done
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ee_wait_r <= 1'h0;
		end else if (launch && launch_ee) begin
			ee_wait_r <= 1'h1;
		end else if (i_mem_done) begin
			ee_wait_r <= 1'h0;
		end
	end

	assign wr_clear = (launch && !launch_ee) || (ee_wait_r && i_mem_done);

	// access control; set of initiate wins over clear
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mac_r <= `MAC_RESET;
		end else begin
			if (sfr_we && pay_full[7:0] == `SFR_MAC) begin
				mac_r[7:2] <= sfr_wdata[7:2];
				mac_r[0]   <= sfr_wdata[0];
			end
			mac_r[`MAC_WR] <= wr_go | (mac_r[`MAC_WR] & ~wr_clear);
		end
	end

	// eeprom address pair, data latch and table latch
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ee_lo_r       <= 8'h00;
			ee_hi_r       <= 8'h00;
			ee_data_r     <= 8'h00;
			table_latch_r <= 8'h00;
		end else if (sfr_we) begin
			case (pay_full[7:0])
				`SFR_EE_ADDR_LO: ee_lo_r <= sfr_wdata;
				`SFR_EE_ADDR_HI: ee_hi_r <= sfr_wdata;
				`SFR_EE_DATA:    ee_data_r <= sfr_wdata;
				`SFR_TBL_LATCH:  table_latch_r <= sfr_wdata;
				default: ;
			endcase
		end
	end

	// pointer plus two
	// table pointer: register write or post-increment
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tp_r <= 22'h00_0000;
		end else if (exec && cmd_r == `CMD_TW_INC) begin
			tp_r <= tp_r + `TW_STEP;
		end else if (sfr_we) begin
			case (pay_full[7:0])
				`SFR_TBL_UPPER: tp_r[21:16] <= sfr_wdata[5:0];
				`SFR_TBL_HIGH:  tp_r[15:8] <= sfr_wdata;
				`SFR_TBL_LOW:   tp_r[7:0] <= sfr_wdata;
				default: ;
			endcase
		end
	end

	assign pctl_hit = (tp_r == `PCTL_ADDR) && mac_r[`MAC_CFG_SEL];
	assign multi    = (pctl_r != 8'h00);

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pctl_r <= `PCTL_RESET;
		end else if (exec && tw_cmd && pctl_hit) begin
			pctl_r <= pay_full[7:0];
		end
	end

	// full buffer
	// word slots loaded in the pointer's eight-byte group
	assign cur_mask = (group_r == tp_r[21:3]) ? mask_r : 4'h0;
	assign slot     = 4'h1 << tp_r[2:1];
	assign full     = ((cur_mask | slot) == 4'hF);

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mask_r  <= 4'h0;
			group_r <= 19'h0_0000;
		end else if (exec && tw_cmd && !pctl_hit) begin
			group_r <= tp_r[21:3];
			if (new_op.kind == nvm_seq_pkg::OP_PROGRAM) begin
				mask_r <= 4'h0;
			end else begin
				mask_r <= cur_mask | slot;
			end
		end
	end

	// requests raised by a launch or a table write
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_program_refused <= 1'h0;
		end else if (exec && cmd_r == `CMD_TW_PROG && !pctl_hit && !multi && !full) begin
			o_program_refused <= 1'h1;
		end
	end

	always_comb begin
		new_valid = 1'h0;
		new_op    = '0;
		new_op.panel       = tp_r[`PANEL_MSB:`PANEL_LSB];
		new_op.multi_panel = multi;
		new_op.id_region   = (tp_r >= `ID_FIRST) && (tp_r <= `ID_LAST);
		new_op.boot_block  = (tp_r <= `BOOT_LAST) && !multi;
		new_op.addr        = tp_r;
		new_op.data        = pay_full;
		if (launch && launch_erase) begin
			new_valid   = 1'h1;
			new_op.kind = nvm_seq_pkg::OP_ERASE_ROW;
			new_op.addr = tp_r & `ROW_MASK;
		end else if (launch && launch_ee) begin
			new_valid   = 1'h1;
			new_op.kind = nvm_seq_pkg::OP_EEPROM_WRITE;
			new_op.addr = {6'h00, ee_hi_r, ee_lo_r};
			new_op.data = {8'h00, ee_data_r};
		end else if (exec && tw_cmd && !pctl_hit) begin
			new_valid = 1'h1;
			if (cmd_r == `CMD_TW_PROG && (multi || full)) begin
				new_op.kind = nvm_seq_pkg::OP_PROGRAM;
			end else begin
				new_op.kind = nvm_seq_pkg::OP_LOAD;
			end
		end
	end

	// holding stage; a stalled buffer stalls it
	assign accept = pend_valid_r & buf_ready;

	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pend_valid_r <= 1'h0;
			pend_op_r    <= '0;
			o_overrun    <= 1'h0;
		end else if (new_valid && pend_valid_r && !accept) begin
			o_overrun <= 1'h1;
		end else if (new_valid) begin
			pend_valid_r <= 1'h1;
			pend_op_r    <= new_op;
		end else if (accept) begin
			pend_valid_r <= 1'h0;
		end
	end

	stream_buffer #(
		.WIDTH ($bits(nvm_seq_pkg::mem_op_type)),
		.DEPTH (BUF_DEPTH)
	) u_buf (
		.i_sys_clk (i_sys_clk),
		.i_rst_b   (i_rst_b),
		.i_valid   (pend_valid_r),
		.o_ready   (buf_ready),
		.i_data    (pend_op_r),
		.o_valid   (o_mem_valid),
		.i_ready   (i_mem_ready),
		.o_data    (o_mem_op)
	);

	// turnaround: drive after eighth payload fall
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prog_serial_data_oe <= 1'h0;
		end else if (fall && state_r == nvm_seq_pkg::ST_PAY && cmd_r == `CMD_SHIFT_OUT) begin
			if (cnt_r == `OUT_TURN_BIT) begin
				o_prog_serial_data_oe <= 1'h1;
			end else if (cnt_r == `PAY_LAST_BIT) begin
				o_prog_serial_data_oe <= 1'h0;
			end
		end
	end

	// latch bits leave lsb first, one per rise
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_prog_serial_data_out <= 1'h0;
		end else if (rise && o_prog_serial_data_oe) begin
			o_prog_serial_data_out <= table_latch_r[cnt_r[2:0]];
		end
	end

	assign o_write_busy   = mac_r[`MAC_WR];
	assign o_single_panel = ~multi;

endmodule

// >>> nvm_seq_regs.svh
// offsets, fields, resets and counts of the sequencer
`ifndef NVM_SEQ_REGS_SVH
`define NVM_SEQ_REGS_SVH

// register addresses used by core instructions
`define SFR_TBL_UPPER   8'hF8
`define SFR_TBL_HIGH    8'hF7
`define SFR_TBL_LOW     8'hF6
`define SFR_TBL_LATCH   8'hF5
`define SFR_MAC         8'hA6
`define SFR_KEY         8'hA7
`define SFR_EE_DATA     8'hA8
`define SFR_EE_ADDR_LO  8'hA9
`define SFR_EE_ADDR_HI  8'hAA

// memory_access_control field positions, then the memory_access_control and programming_control resets
`define MAC_PGM_SEL     7
`define MAC_CFG_SEL     6
`define MAC_ROW_ERASE   4
`define MAC_WRITE_ENABLE_BIT        2
`define MAC_WR          1
`define MAC_RESET       8'h00
`define PCTL_RESET      8'h00

// unlock key sequence
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'hAA

// 4-bit commands
`define CMD_CORE        4'h0
`define CMD_SHIFT_OUT   4'h2
`define CMD_TW          4'hC
`define CMD_TW_INC      4'hD
`define CMD_TW_PROG     4'hF

// address map
`define PCTL_ADDR       22'h3C_0006
`define ID_FIRST        22'h20_0000
`define ID_LAST         22'h20_0007
`define BOOT_LAST       22'h00_07FF
`define ROW_MASK        22'h3F_FFC0
`define TW_STEP         22'h00_0002
`define PANEL_MSB       15
`define PANEL_LSB       13

// framing and timing counts, in serial clock edges
`define CMD_LAST_BIT    4'h3
`define PAY_LAST_BIT    4'hF
`define OUT_TURN_BIT    4'h7
`define ERASE_START_EDGES 3'h4

`endif

// >>> nvm_seq_pkg.sv
// types of the programming sequencer
package nvm_seq_pkg;

	// serial framing phases
	typedef enum logic [0:0] {
		ST_CMD = 1'b0,
		ST_PAY = 1'b1
	} link_state_type;

	// unlock key progress
	typedef enum logic [1:0] {
		KEY_IDLE  = 2'b00,
		KEY_HALF  = 2'b01,
		KEY_ARMED = 2'b10
	} key_state_type;

	// kinds of request sent to the memory arrays
	typedef enum logic [1:0] {
		OP_LOAD         = 2'b00,
		OP_PROGRAM      = 2'b01,
		OP_ERASE_ROW    = 2'b10,
		OP_EEPROM_WRITE = 2'b11
	} mem_op_kind_type;

	// one memory request
	typedef struct packed {
		mem_op_kind_type kind;
		logic            multi_panel;
		logic [2:0]      panel;
		logic            id_region;
		logic            boot_block;
		logic [21:0]     addr;
		logic [15:0]     data;
	} mem_op_type;

endpackage

// >>> pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	// raw pins and filtered levels
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_level
);

	logic [WIDTH-1:0] s1_r;    // first stage, read only by s2_r
	logic [WIDTH-1:0] s2_r;    // second stage
	logic [WIDTH-1:0] s3_r;    // third stage
	logic [WIDTH-1:0] agree;   // second and third stage match

	generate
		if (WIDTH < 1) begin : g_chk
			$error("pin_sync width must be positive");
		end
	endgenerate

	assign agree = ~(s2_r ^ s3_r);

	// shift chain
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= i_async;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// level follows once two stages agree
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_level <= '0;
		end else begin
			o_level <= (agree & s3_r) | (~agree & o_level);
		end
	end

endmodule

// >>> stream_buffer.sv
// small valid/ready buffer for memory requests
`timescale 1ns/10ps
module stream_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_rst_b,
	// filling side
	input  wire logic             i_valid,
	output logic                  o_ready,
	input  wire logic [WIDTH-1:0] i_data,
	// draining side
	output logic                  o_valid,
	input  wire logic             i_ready,
	output logic      [WIDTH-1:0] o_data
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW:0] FULL = DEPTH[AW:0];

	logic [WIDTH-1:0] mem_r [DEPTH];  // storage entries
	logic [AW-1:0]    wr_idx_r;       // next slot to fill
	logic [AW-1:0]    rd_idx_r;       // oldest slot
	logic [AW:0]      count_r;        // entries held
	logic             push;
	logic             pop;

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
			$error("stream_buffer depth must be a power of two, at least 2");
		end
	endgenerate

	assign o_ready = (count_r != FULL);
	assign o_valid = (count_r != '0);
	assign o_data  = mem_r[rd_idx_r];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	// entry storage
	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem_r[wr_idx_r] <= i_data;
		end
	end

	// pointers and fill count; indices wrap at the depth
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wr_idx_r <= '0;
			rd_idx_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) begin
				wr_idx_r <= wr_idx_r + 1'h1;
			end
			if (pop) begin
				rd_idx_r <= rd_idx_r + 1'h1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'h1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'h1;
			end
		end
	end

endmodule

// >>> nvm_seq_monitor.sv
// port assertions of the programming sequencer
`timescale 1ns/10ps
`include "nvm_seq_regs.svh"
module nvm_seq_monitor (
	// clock and reset
	input wire logic	i_sys_clk,
	input wire logic	i_rst_b,
	// watched ports
	input wire logic	i_mem_ready,
	input wire logic	i_mem_done,
	input wire logic	o_mem_valid,
	input wire nvm_seq_pkg::mem_op_type	o_mem_op,
	input wire logic	o_write_busy,
	input wire logic	o_program_refused
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_b);
	wire	[21:0] ad = o_mem_op.addr;	// head address
	wire	ee = o_mem_op.kind == nvm_seq_pkg::OP_EEPROM_WRITE;	// eeprom head
	wire	cd = o_mem_valid && !ee;	// code head
	a_head_holds: assert property (o_mem_valid && !i_mem_ready
		|=> o_mem_valid && $stable(o_mem_op)) else $error("head moved");
	a_refuse_sticky: assert property (o_program_refused |=> o_program_refused)
		else $error("refused dropped");
	a_erase_row: assert property (cd && o_mem_op.kind == nvm_seq_pkg::OP_ERASE_ROW
		|-> ad[5:0] == 6'h00) else $error("erase unaligned");
	a_id_flag: assert property (cd
		|-> o_mem_op.id_region == (ad >= `ID_FIRST && ad <= `ID_LAST)) else $error("id flag");
	a_boot_flag: assert property (cd
		|-> o_mem_op.boot_block == (ad <= `BOOT_LAST && !o_mem_op.multi_panel)) else $error("boot");
	a_panel_pick: assert property (cd |-> o_mem_op.panel == ad[15:13])
		else $error("panel");
	a_busy_done: assert property (o_write_busy && i_mem_done |=> !o_write_busy)
		else $error("busy held");
	a_ee_fields: assert property (o_mem_valid && ee
		|-> ad[21:16] == 6'h00 && o_mem_op.data[15:8] == 8'h00) else $error("eeprom fields");
	cover property (o_mem_valid && !i_mem_ready);
	cover property (cd && o_mem_op.kind == nvm_seq_pkg::OP_ERASE_ROW);
	cover property (o_write_busy && i_mem_done);
endmodule
bind nvm_modify_and_eeprom_write nvm_seq_monitor mon (.*);

// >>> mem_array_model.sv
// memory stand-in: stalls, times eeprom bytes
`timescale 1ns/10ps
module mem_array_model (
	// clock and reset
	input wire logic	i_sys_clk,
	input wire logic	i_rst_b,
	// request stream
	input wire logic	i_mem_valid,
	input wire nvm_seq_pkg::mem_op_type	i_mem_op,
	output logic	o_mem_ready,
	output logic	o_mem_done,
	// stall controls
	input wire logic	i_slow,
	input wire logic	i_hold
);
	logic	[9:0] left_r;	// cycles left on an eeprom byte
	logic	[1:0] tick_r;	// patchy stall pattern
	// ready and byte timing
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			{left_r, tick_r, o_mem_ready, o_mem_done} <= '0;
		end else begin
			tick_r <= tick_r + 2'h1;
			o_mem_ready <= !i_hold && (!i_slow || tick_r[1]);
			o_mem_done <= left_r == 10'h001;
			left_r <= left_r - 10'(left_r != 10'h000);
			if (i_mem_valid && o_mem_ready && i_mem_op.kind == nvm_seq_pkg::OP_EEPROM_WRITE) begin
				left_r <= 10'h3E8;
			end
		end
	end
endmodule

// >>> nvm_modify_and_eeprom_write_test.sv
// bench of the programming sequencer
`timescale 1ns/10ps
`include "nvm_seq_regs.svh"
module nvm_modify_and_eeprom_write_test;
	logic	clk, rst_b, prog_serial_clock, pgd_tb, slow, hold, oe, dout, vld, rdy, done, busy, sp, refd, ovr;
	logic	[31:0] rs;	// xorshift state
	logic	[21:0] a;	// working address
	logic	[7:0] rd;	// bits seen on the wire
	nvm_seq_pkg::mem_op_type	op, e, q[$];	// head, expected, model queue
	int	failures, num_checks;
	wire	prog_serial_data = oe ? dout : pgd_tb;	// shared data wire
	nvm_modify_and_eeprom_write uut (.i_sys_clk(clk), .i_rst_b(rst_b),
		.i_prog_serial_clock(prog_serial_clock), .i_prog_serial_data(prog_serial_data), .o_prog_serial_data_out(dout),
		.o_prog_serial_data_oe(oe), .o_mem_valid(vld), .i_mem_ready(rdy), .o_mem_op(op),
		.i_mem_done(done), .o_write_busy(busy), .o_single_panel(sp),
		.o_program_refused(refd), .o_overrun(ovr));
	mem_array_model mem (.i_sys_clk(clk), .i_rst_b(rst_b), .i_mem_valid(vld), .i_mem_op(op),
		.o_mem_ready(rdy), .o_mem_done(done), .i_slow(slow), .i_hold(hold));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction
	// expected single-panel request
	function automatic nvm_seq_pkg::mem_op_type ex(input logic [1:0] k, input logic [21:0] x,
		input logic [15:0] d);
		return {k, 1'b0, x[15:13], x >= `ID_FIRST && x <= `ID_LAST, x <= `BOOT_LAST, x, d};
	endfunction
	// one serial bit, 80 ns, read late in the high phase
	task automatic bt(input logic b);
		pgd_tb = b;
		prog_serial_clock = 1'b1;
		repeat (5) @(negedge clk);
		rd = {prog_serial_data, rd[7:1]};
		prog_serial_clock = 1'b0;
		repeat (5) @(negedge clk);
	endtask
	task automatic cmd(input logic [3:0] c, input logic [15:0] p);
		for (int i = 0; i < 20; i++) bt(i < 4 ? c[i] : p[i - 4]);
		repeat (3) @(negedge clk);
	endtask
	task automatic ptr(input logic [21:0] x);
		for (int i = 0; i < 3; i++) begin
			cmd(4'h0, {8'h0E, 8'({2'b00, x} >> (16 - 8 * i))});
			cmd(4'h0, {8'h6E, 8'hF8 - 8'(i)});
		end
	endtask
	task automatic unlock(input logic [7:0] k1, k2);
		cmd(4'h0, {8'h0E, k1});
		cmd(4'h0, 16'h6EA7);
		cmd(4'h0, {8'h0E, k2});
		cmd(4'h0, 16'h6EA7);
		cmd(4'h0, 16'h82A6);
		cmd(4'h0, 16'h0000);
	endtask
	task automatic poll();
		cmd(4'h0, 16'h50A6);
		cmd(4'h0, 16'h6EF5);
		cmd(4'h2, 16'h0000);
	endtask
	task automatic chk_v(input string n, input logic [7:0] x, g);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic chk_o(input nvm_seq_pkg::mem_op_type x, g);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("CHECK FAILED mem_op exp %h got %h", x, g);
		end
	endtask
	task automatic fin(input string n);
		for (int i = 0; i < 300 && q.size() > 0; i++) @(negedge clk);
		chk_v(n, 8'h00, 8'(q.size()));
		$display("test %s done", n);
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// each accepted request against the model
	always @(posedge clk) begin
		if (vld === 1'b1 && rdy === 1'b1) begin
			e = q.size() > 0 ? q.pop_front() : '1;
			if (e.kind == 2'b10) e.data = op.data;
			if (e.kind == 2'b11) e[42:38] = op[42:38];
			chk_o(e, op);
		end
	end
	initial begin
		#400_000;
		failures++;
		wrap_up();
	end
	initial begin
		{prog_serial_clock, pgd_tb, slow, hold, rst_b} = 5'h00;
		rs = 32'h0000_38A3;
		failures = 0;
		num_checks = 0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		cmd(4'h0, 16'h8EA6);
		cmd(4'h0, 16'h8CA6);
		ptr(`PCTL_ADDR);
		cmd(4'hC, 16'h0040);
		chk_v("panel", 8'h00, 8'(sp));
		cmd(4'hC, 16'h0000);
		chk_v("panel", 8'h01, 8'(sp));
		cmd(4'h0, 16'h9CA6);
		fin("panel_mode");
		// erase refused without enable or key, then taken
		rs = xs(rs);
		a = {6'h00, rs[15:0]};
		ptr(a);
		cmd(4'h0, 16'h88A6);
		unlock(8'h55, 8'hAA);
		cmd(4'h0, 16'h84A6);
		unlock(8'hAA, 8'h55);
		fin("erase_refused");
		q.push_back(ex(2'b10, a & `ROW_MASK, 16'h0000));
		unlock(8'h55, 8'hAA);
		chk_v("busy", 8'h00, 8'(busy));
		fin("erase");
		cmd(4'h0, 16'h98A6);
		// buffered writes in code, ID and boot space
		for (int j = 0; j < 3; j++) begin
			rs = xs(rs);
			slow = rs[16];
			a = j == 0 ? {6'h00, rs[15:3], 3'h0} : j == 1 ? `ID_FIRST : {11'h000, rs[10:3], 3'h0};
			ptr(a);
			for (int k = 0; k < 4; k++) begin
				rs = xs(rs);
				q.push_back(ex(k < 3 ? 2'b00 : 2'b01, 22'(a + 2 * k), rs[15:0]));
				cmd(k < 3 ? 4'hD : 4'hF, rs[15:0]);
			end
			chk_v("refused", 8'h00, 8'(refd));
			fin("group_write");
		end
		// eeprom byte write and poll
		rs = xs(rs);
		cmd(4'h0, 16'h9EA6);
		for (int i = 0; i < 3; i++) begin
			cmd(4'h0, {8'h0E, rs[8 * i +: 8]});
			cmd(4'h0, {8'h6E, 8'hA8 + 8'(i)});
		end
		cmd(4'h0, 16'h84A6);
		q.push_back(ex(2'b11, {6'h00, rs[23:8]}, {8'h00, rs[7:0]}));
		unlock(8'h55, 8'hAA);
		poll();
		chk_v("control", 8'h06, rd);
		for (int i = 0; i < 5 && rd[1] === 1'b1; i++) poll();
		chk_v("control", 8'h04, rd);
		cmd(4'h0, 16'h94A6);
		fin("eeprom");
		// memory held off: fourth word dropped
		cmd(4'h0, 16'h8EA6);
		hold = 1'b1;
		a = 22'h00_1000;
		ptr(a);
		for (int k = 0; k < 4; k++) begin
			if (k < 3) q.push_back(ex(2'b00, 22'(a + 2 * k), 16'(k)));
			cmd(4'hD, 16'(k));
		end
		chk_v("overrun", 8'h01, 8'(ovr));
		hold = 1'b0;
		fin("overrun");
		// last word of an unloaded group
		ptr(22'h00_2000);
		q.push_back(ex(2'b00, 22'h00_2000, 16'h1234));
		cmd(4'hF, 16'h1234);
		chk_v("refused", 8'h01, 8'(refd));
		fin("refused");
		wrap_up();
	end
endmodule
